// File: rtl/sbs_sram.sv
`timescale 1ns/10ps
// Behaviour
// - the part is selected only with first select low, second high and third low.
// - all four lanes are written when global write is low, or when the byte gate and all four byte writes are low.
// - after a write the data pins float until a read is taken on an address strobe or a burst step.
// - the data pins are floating when the part comes out of sleep.
// - after the last word of a burst the counter wraps to the first burst address.
// - an address strobe with the part selected during a burst loads the new base and the burst goes on from it.
module sbs_sram
    import sbs_pkg::*;
(
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [sbs_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                       chip_select_low_first_i,
    input  wire logic                       chip_select_high_second_i,
    input  wire logic                       chip_select_low_third_i,
    input  wire logic                       processor_addr_strobe_n_i,
    input  wire logic                       controller_addr_strobe_n_i,
    input  wire logic                       burst_step_n_i,
    input  wire logic                       global_write_n_i,
    input  wire logic                       byte_write_gate_n_i,
    input  wire logic [sbs_pkg::LANES-1:0]  per_byte_write_n_i,
    input  wire logic                       output_enable_n_i,
    input  wire logic                       linear_burst_i,
    input  wire logic                       sleep_request_i,
    input  wire logic [sbs_pkg::DATA_W-1:0] dq_i,
    output logic      [sbs_pkg::DATA_W-1:0] dq_o,
    output logic                            dq_oe_n_o
);
    import sbs_pkg::*;

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic              sleep_meta;
    logic              asleep;
    logic              active;
    logic              out_live;
    logic              next_live;
    logic              selected;
    logic              strobe;
    logic              wr_full;
    logic [LANES-1:0]  wr_lanes;
    logic              access;
    logic              wr_cyc;
    logic              rd_cyc;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] adv_addr;
    logic [ADDR_W-1:0] eff_addr;
    sbs_cyc_e          cyc;

    // sleep may be driven by slow board logic, so it is synchronised
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_meta <= 1'b0;
            asleep     <= 1'b0;
        end else begin
            sleep_meta <= sleep_request_i;
            asleep     <= sleep_meta;
        end
    end

    assign selected = !chip_select_low_first_i && chip_select_high_second_i
                      && !chip_select_low_third_i;
    assign strobe   = !processor_addr_strobe_n_i || !controller_addr_strobe_n_i;

    always_comb begin
        if (asleep) begin
            cyc = CYC_SLEEP;
        end else if (strobe && !selected) begin
            cyc = CYC_DESELECT;
        end else if (strobe) begin
            cyc = CYC_NEW;
        end else if (active && !burst_step_n_i) begin
            cyc = CYC_STEP;
        end else begin
            cyc = CYC_HOLD;
        end
    end

    assign wr_full = !global_write_n_i
                     || (!byte_write_gate_n_i && per_byte_write_n_i == LANES_NONE);

    always_comb begin
        if (wr_full) begin
            wr_lanes = LANES_ALL;
        end else if (!byte_write_gate_n_i) begin
            wr_lanes = ~per_byte_write_n_i;
        end else begin
            wr_lanes = LANES_NONE;
        end
    end

    // a processor strobe always opens with a read; writes follow on later cycles
    assign access = (cyc == CYC_NEW) || (active && (cyc == CYC_STEP || cyc == CYC_HOLD));
    assign wr_cyc = access && wr_lanes != LANES_NONE
                    && !(cyc == CYC_NEW && !processor_addr_strobe_n_i);
    assign rd_cyc = access && !wr_cyc;

    always_comb begin
        unique case (cyc)
            CYC_NEW:  eff_addr = addr_i;
            CYC_STEP: eff_addr = adv_addr;
            default:  eff_addr = cur_addr;
        endcase
    end

    sbs_burst_ctr u_burst (
        .sys_clk_i  (sys_clk_i),
        .rst_b_i    (rst_b_i),
        .load_i     (cyc == CYC_NEW),
        .base_i     (addr_i),
        .advance_i  (cyc == CYC_STEP),
        .linear_i   (linear_burst_i),
        .cur_addr_o (cur_addr),
        .adv_addr_o (adv_addr)
    );

    // sleep and deselect end the burst, so a stray step afterwards is ignored
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active <= 1'b0;
        end else if (cyc == CYC_SLEEP || cyc == CYC_DESELECT) begin
            active <= 1'b0;
        end else if (cyc == CYC_NEW) begin
            active <= 1'b1;
        end
    end

    // contents are not reset; a read of an unwritten word returns unknowns
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge sys_clk_i) begin
                if (wr_cyc && wr_lanes[g]) begin
                    mem[eff_addr][g*LANE_W +: LANE_W] <= dq_i[g*LANE_W +: LANE_W];
                end
            end
        end
    endgenerate

    // a suspend after a read keeps driving; after a write it keeps floating
    always_comb begin
        if (cyc == CYC_SLEEP || cyc == CYC_DESELECT || wr_cyc) begin
            next_live = 1'b0;
        end else if (rd_cyc && cyc != CYC_HOLD) begin
            next_live = 1'b1;
        end else begin
            next_live = out_live && active;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_live <= 1'b0;
        end else begin
            out_live <= next_live;
        end
    end

    // output enable is sampled with the clock, so it acts one edge late
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_oe_n_o <= 1'b1;
        end else begin
            dq_oe_n_o <= !(next_live && !output_enable_n_i);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_o <= DATA_ZERO;
        end else if (rd_cyc) begin
            dq_o <= mem[eff_addr];
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_select_decode: assert property (
        (strobe && !asleep && (chip_select_low_first_i || !chip_select_high_second_i
                               || chip_select_low_third_i))
        |=> dq_oe_n_o && !active)
        else $error("access taken while not selected");
    chk_full_write: assert property (
        (wr_cyc && (!global_write_n_i
                    || (!byte_write_gate_n_i && per_byte_write_n_i == LANES_NONE)))
        |=> mem[$past(eff_addr)] == $past(dq_i))
        else $error("full width write lost data");
    chk_float_after_wr: assert property (
        wr_cyc |=> dq_oe_n_o)
        else $error("data pins driven right after a write");
    chk_float_suspend: assert property (
        (wr_cyc ##1 (cyc == CYC_HOLD && !wr_cyc)) |=> dq_oe_n_o)
        else $error("data pins driven on a suspend after a write");
    chk_sleep_float: assert property (
        asleep |=> dq_oe_n_o && !active)
        else $error("data pins driven during sleep");
    chk_wake_float: assert property (
        $fell(asleep) |-> dq_oe_n_o)
        else $error("data pins driven when leaving sleep");
    chk_burst_wrap: assert property (
        (cyc == CYC_NEW ##1 (cyc == CYC_STEP)[*4]) |-> eff_addr == $past(eff_addr, 4))
        else $error("burst did not wrap to its first address");
    chk_burst_restart: assert property (
        (cyc == CYC_STEP ##1 cyc == CYC_NEW) |=> cur_addr == $past(addr_i))
        else $error("burst did not restart from the new base");
    chk_hold_addr: assert property (
        (cyc == CYC_STEP ##1 cyc == CYC_HOLD) |-> eff_addr == $past(eff_addr))
        else $error("burst address moved without a step");
    chk_read_drive: assert property (
        (rd_cyc && cyc != CYC_HOLD && !output_enable_n_i)
        |=> !dq_oe_n_o && dq_o == mem[$past(eff_addr)])
        else $error("read data not driven one edge after the access");

    cov_burst_four: cover property (cyc == CYC_NEW ##1 (cyc == CYC_STEP)[*4]);
    cov_write_read: cover property (wr_cyc ##1 rd_cyc ##1 !dq_oe_n_o);
    cov_restart: cover property (cyc == CYC_STEP ##1 cyc == CYC_NEW);
    cov_sleep_exit: cover property ($fell(asleep));
    cov_byte_lanes: cover property (wr_cyc && wr_lanes != LANES_ALL);
endmodule

// File: rtl/sbs_pkg.sv
package sbs_pkg;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 32;
    localparam int LANE_W    = 8;
    localparam int LANES     = 4;
    localparam int MEM_DEPTH = 65536;
    localparam int BURST_W   = 2;

    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
    localparam logic [LANES-1:0]   LANES_ALL  = 4'hF;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 16'h0000;
    localparam logic [DATA_W-1:0]  DATA_ZERO  = 32'h0000_0000;

    typedef enum logic [2:0] {
        CYC_SLEEP,
        CYC_DESELECT,
        CYC_NEW,
        CYC_STEP,
        CYC_HOLD
    } sbs_cyc_e;
endpackage

// File: rtl/sbs_burst_ctr.sv
`timescale 1ns/10ps
module sbs_burst_ctr
    import sbs_pkg::*;
(
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_b_i,
    input  wire logic                      load_i,
    input  wire logic [sbs_pkg::ADDR_W-1:0] base_i,
    input  wire logic                      advance_i,
    input  wire logic                      linear_i,
    output logic      [sbs_pkg::ADDR_W-1:0] cur_addr_o,
    output logic      [sbs_pkg::ADDR_W-1:0] adv_addr_o
);
    logic [ADDR_W-1:0]  base;
    logic [BURST_W-1:0] cnt;
    logic [BURST_W-1:0] next_cnt;

    // two-bit count rolls over by itself, so the fifth word is the first again
    assign next_cnt = cnt + BURST_ONE;

    function automatic logic [ADDR_W-1:0] offset(input logic [BURST_W-1:0] c);
        logic [BURST_W-1:0] low;
        low = linear_i ? base[BURST_W-1:0] + c : base[BURST_W-1:0] ^ c;
        return {base[ADDR_W-1:BURST_W], low};
    endfunction

    assign cur_addr_o = offset(cnt);
    assign adv_addr_o = offset(next_cnt);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base <= ADDR_ZERO;
            cnt  <= BURST_ZERO;
        end else if (load_i) begin
            base <= base_i;
            cnt  <= BURST_ZERO;
        end else if (advance_i) begin
            cnt <= next_cnt;
        end
    end
endmodule

// File: test/sbs_ctl_model.sv
`timescale 1ns/10ps
module sbs_ctl_model
    import sbs_pkg::*;
(
    input  wire logic                       sys_clk_i,
    output logic      [sbs_pkg::ADDR_W-1:0] addr_o,
    output logic                            chip_select_low_first_o,
    output logic                            chip_select_high_second_o,
    output logic                            chip_select_low_third_o,
    output logic                            processor_addr_strobe_n_o,
    output logic                            controller_addr_strobe_n_o,
    output logic                            burst_step_n_o,
    output logic                            global_write_n_o,
    output logic                            byte_write_gate_n_o,
    output logic      [sbs_pkg::LANES-1:0]  per_byte_write_n_o,
    output logic                            sleep_request_o,
    output logic      [sbs_pkg::DATA_W-1:0] dq_o
);
    localparam int POWER_WAIT = 40000; // 1 ms at 40 MHz
    initial begin
        {addr_o, dq_o} = '0;
        {chip_select_low_first_o, chip_select_high_second_o, chip_select_low_third_o} = 3'h5;
        {processor_addr_strobe_n_o, controller_addr_strobe_n_o, burst_step_n_o} = 3'h7;
        {global_write_n_o, byte_write_gate_n_o, per_byte_write_n_o} = 6'h3F;
        sleep_request_o = 1'b0;
    end
    task automatic power_wait();
        repeat (POWER_WAIT) @(posedge sys_clk_i);
    endtask
    // one bus cycle, set up at the falling edge, taken at the next rising edge
    task automatic cyc(input logic [2:0] cs, input logic p, c, s, g, b,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge sys_clk_i);
        {chip_select_low_first_o, chip_select_high_second_o, chip_select_low_third_o} = cs;
        {processor_addr_strobe_n_o, controller_addr_strobe_n_o, burst_step_n_o} = {p, c, s};
        {global_write_n_o, byte_write_gate_n_o, per_byte_write_n_o} = {g, b, {4{b}}};
        addr_o = a;
        // data lines not written carry no stale value
        dq_o = (g & b) ? ~dq_o : d;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic nap(input int n);
        cyc(3'h5, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, ADDR_ZERO, DATA_ZERO);
        @(negedge sys_clk_i);
        sleep_request_o = 1'b1;
        repeat (n) @(negedge sys_clk_i);
        sleep_request_o = 1'b0;
        repeat (3) @(negedge sys_clk_i);
    endtask
    // a write through the byte gate with only some lanes enabled
    task automatic byte_wr(input logic [LANES-1:0] bw, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
        @(negedge sys_clk_i);
        {chip_select_low_first_o, chip_select_high_second_o, chip_select_low_third_o} = 3'h2;
        {processor_addr_strobe_n_o, controller_addr_strobe_n_o, burst_step_n_o} = 3'h5;
        {global_write_n_o, byte_write_gate_n_o, per_byte_write_n_o} = {2'h2, bw};
        addr_o = a;
        dq_o = d;
        @(posedge sys_clk_i);
        #1;
    endtask
endmodule

// File: test/sbs_sram_tb_top.sv
`timescale 1ns/10ps
module sbs_sram_tb_top;
    import sbs_pkg::*;
    logic              sys_clk, rst_b, cs1, cs2, cs3, pst_n, cst_n, step_n, gw_n, bg_n, slp;
    logic              oe_n, linear, dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  bw_n;
    logic [DATA_W-1:0] dq_w, dq_r;
    int                num_errors, total_checks, cycles;
    localparam logic [2:0] SEL = 3'h2;
    sbs_ctl_model m (.sys_clk_i(sys_clk), .addr_o(addr), .chip_select_low_first_o(cs1),
        .chip_select_high_second_o(cs2), .chip_select_low_third_o(cs3),
        .processor_addr_strobe_n_o(pst_n), .controller_addr_strobe_n_o(cst_n),
        .burst_step_n_o(step_n), .global_write_n_o(gw_n), .byte_write_gate_n_o(bg_n),
        .per_byte_write_n_o(bw_n), .sleep_request_o(slp), .dq_o(dq_w));
    sbs_sram dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr),
        .chip_select_low_first_i(cs1), .chip_select_high_second_i(cs2),
        .chip_select_low_third_i(cs3), .processor_addr_strobe_n_i(pst_n),
        .controller_addr_strobe_n_i(cst_n), .burst_step_n_i(step_n),
        .global_write_n_i(gw_n), .byte_write_gate_n_i(bg_n), .per_byte_write_n_i(bw_n),
        .output_enable_n_i(oe_n), .linear_burst_i(linear), .sleep_request_i(slp),
        .dq_i(dq_w), .dq_o(dq_r), .dq_oe_n_o(dq_oe_n));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // read cycle by controller strobe, or a burst step when st is set
    task automatic rd(input logic st, input logic [ADDR_W-1:0] a, input logic [7:0] w);
        m.cyc(SEL, 1'b1, st, ~st, 1'b1, 1'b1, a, DATA_ZERO);
        chk("read data", 32'hA000_0000 + w, dq_r);
        chk("drive", 32'h0, {31'h0, dq_oe_n});
    endtask
    task automatic t_burst();
        for (int i = 0; i < 4; i++) begin
            m.cyc(SEL, 1'b1, 1'b0, 1'b1, i[0], ~i[0], 16'h0010 + i, 32'hA000_0000 + i);
            chk("float after write", 32'h1, {31'h0, dq_oe_n});
        end
        m.cyc(SEL, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_ZERO, DATA_ZERO);
        chk("float on hold", 32'h1, {31'h0, dq_oe_n});
        linear = 1'b1;
        rd(1'b0, 16'h0010, 8'h0);
        rd(1'b1, ADDR_ZERO, 8'h1);
        m.cyc(SEL, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_ZERO, DATA_ZERO);
        chk("hold data", 32'hA000_0001, dq_r);
        rd(1'b1, ADDR_ZERO, 8'h2);
        rd(1'b1, ADDR_ZERO, 8'h3);
        rd(1'b1, ADDR_ZERO, 8'h0);
        $display("test burst done");
    endtask
    task automatic t_restart();
        linear = 1'b0;
        rd(1'b0, 16'h0012, 8'h2);
        rd(1'b1, ADDR_ZERO, 8'h3);
        m.cyc(SEL, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0011, DATA_ZERO);
        chk("restart data", 32'hA000_0001, dq_r);
        rd(1'b1, ADDR_ZERO, 8'h0);
        // interleaved walk from the new base: 1^2, 1^3, then back to 1
        rd(1'b1, ADDR_ZERO, 8'h3);
        rd(1'b1, ADDR_ZERO, 8'h2);
        rd(1'b1, ADDR_ZERO, 8'h1);
        $display("test restart done");
    endtask
    task automatic t_select();
        for (int k = 0; k < 8; k++) begin
            m.cyc(k[2:0], 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0010, DATA_ZERO);
            chk("select", {31'h0, k != 2}, {31'h0, dq_oe_n});
        end
        $display("test select done");
    endtask
    task automatic t_sleep();
        rd(1'b0, 16'h0011, 8'h1);
        m.nap(6);
        chk("float after sleep", 32'h1, {31'h0, dq_oe_n});
        rd(1'b0, 16'h0013, 8'h3);
        $display("test sleep done");
    endtask
    task automatic t_output_enable();
        @(negedge sys_clk);
        oe_n = 1'b1;
        m.cyc(SEL, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0012, DATA_ZERO);
        chk("drive with enable off", 32'h1, {31'h0, dq_oe_n});
        chk("data with enable off", 32'hA000_0002, dq_r);
        @(negedge sys_clk);
        oe_n = 1'b0;
        m.cyc(SEL, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ADDR_ZERO, DATA_ZERO);
        chk("drive with enable on", 32'h0, {31'h0, dq_oe_n});
        $display("test output enable done");
    endtask
    task automatic t_lanes();
        m.byte_wr(4'hA, 16'h0013, 32'h5566_7788);
        chk("float after byte write", 32'h1, {31'h0, dq_oe_n});
        m.cyc(SEL, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 16'h0013, DATA_ZERO);
        chk("byte lanes", 32'hA066_0088, dq_r);
        chk("drive after byte write", 32'h0, {31'h0, dq_oe_n});
        $display("test lanes done");
    endtask
    initial begin
        {rst_b, oe_n, linear, num_errors, total_checks, cycles} = '0;
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        m.power_wait();
        t_burst();
        t_restart();
        t_select();
        t_sleep();
        t_output_enable();
        t_lanes();
        end_of_test();
    end
endmodule
